/* src/accel_motion_power_selftest_ctrl.sv */
// rate decimation, motion detectors, link/autosleep, interrupt cause, self-test
//
// Overview of operation
// - all output rates come from decimating one shared sample stream
// - activity, free-fall and tap detectors look at unfiltered samples
// - with link set, activity is armed only after inactivity, alternating
// - reading the interrupt cause register clears activity/inactivity flags
// - no autosleep while an activity interrupt is still pending
// - asleep flag is readable in the motion/tap status register
// - data-ready interrupt is suppressed while asleep
// - low-power bit reduces power but data collection keeps running
// - rate field is bits 3:0; codes 0x0A and up give 100 Hz or more
// - format bit 3 full resolution, range 0x03 is 16 g, 3.9 mg/LSB
// - format bit 7 enables self-test shift on every axis; clear disables
`timescale 1ns/1ns
module accel_motion_power_selftest_ctrl
  import accel_ctrl_pkg::*;
#(
  parameter logic signed [SAMPLE_W-1:0] ST_SHIFT = 13'sh0080
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  // shared raw sample stream at the top rate
  input  wire logic        sampleValid,
  input  wire axes_t       rawSample,
  // detector settings
  input  wire logic [7:0]  actThresh,
  input  wire logic [7:0]  inactThresh,
  input  wire logic [7:0]  inactSamples,
  input  wire logic [7:0]  ffThresh,
  input  wire logic [7:0]  tapThresh,
  input  wire logic        linkEnable,
  input  wire logic        autoSleepEnable,
  input  wire logic [7:0]  intEnable,
  // outputs
  output axes_t            dataOut,
  output logic             dataReady,
  output logic             intOut,
  output logic             asleep,
  output logic             lowPowerMode,
  output logic             fastRate,
  output logic             selfTestOn
);

  logic [7:0]          rateReg, fmtReg, cause, inactCnt;
  logic [6:0]          motionStat;
  link_state_t         linkState;
  logic [DECIM_W-1:0]  decimCnt;
  logic                tapPrev;

  logic [7:0]          next_rateReg, next_fmtReg, next_cause;
  logic [7:0]          next_inactCnt, next_regRdData;
  logic [6:0]          next_motionStat;
  link_state_t         next_linkState;
  logic [DECIM_W-1:0]  next_decimCnt;
  logic                next_tapPrev, next_asleep, next_dataReady;
  axes_t               next_dataOut;

  logic signed [SAMPLE_W-1:0] rawAx  [AXES];
  logic signed [SAMPLE_W-1:0] stAx   [AXES];
  logic signed [SAMPLE_W-1:0] filt   [AXES];
  logic signed [SAMPLE_W-1:0] scaled [AXES];
  logic [AXES-1:0]     actHit, inactLow, ffLow, tapHit;
  logic [DECIM_W-1:0]  rateMask;
  logic                decimEvt, actEvt, inactEvt, ffEvt, tapEvt;
  logic                rdCause, actArmed, inactArmed;

  // x is index 0; status lists x in its top bit, so vectors get reversed
  assign rawAx[0] = rawSample.x;
  assign rawAx[1] = rawSample.y;
  assign rawAx[2] = rawSample.z;

  // per-axis self-test shift, magnitude compares and output filter
  for (genvar a = 0; a < AXES; a++)
  begin : g_axis
    logic [SAMPLE_W-1:0]        mag;
    logic signed [SAMPLE_W:0]   sum;
    logic signed [SAMPLE_W-1:0] next_filt;
    assign stAx[a] = fmtReg[FMT_SELF_TEST] ?
                     SAMPLE_W'(rawAx[a] + ST_SHIFT) : rawAx[a];
    assign mag = stAx[a][SAMPLE_W-1] ? SAMPLE_W'(-stAx[a])
                                     : SAMPLE_W'(stAx[a]);
    // thresholds step in 16 LSB units; compares use the raw path
    assign actHit[a]   = mag >  {1'b0, actThresh, 4'h0};
    assign inactLow[a] = mag <= {1'b0, inactThresh, 4'h0};
    assign ffLow[a]    = mag <  {1'b0, ffThresh, 4'h0};
    assign tapHit[a]   = mag >  {1'b0, tapThresh, 4'h0};
    // averager of new sample and last filter output: output is smoothed, detectors are not
    assign sum = {filt[a][SAMPLE_W-1], filt[a]}
               + {stAx[a][SAMPLE_W-1], stAx[a]};
    assign next_filt = sampleValid ? SAMPLE_W'(sum >>> 1) : filt[a];
    // fixed 10-bit mode drops range bits; full resolution keeps them
    assign scaled[a] = fmtReg[FMT_FULL_RES] ? filt[a]
                                            : filt[a] >>> fmtReg[1:0];
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        filt[a] <= '0;
      else
        filt[a] <= next_filt;
    end
  end

  // one counter on the shared stream serves every rate code
  assign rateMask = DECIM_FULL >> rateReg[RATE_FIELD_HI:0];
  assign decimEvt = sampleValid && ((decimCnt & rateMask) == rateMask);

  // event strobes; link arming steers which detector may fire
  assign actArmed   = !linkEnable || (linkState == WATCH_ACT);
  assign inactArmed = !linkEnable || (linkState == WATCH_INACT);
  assign actEvt   = sampleValid && (|actHit) && actArmed;
  assign inactEvt = sampleValid && (&inactLow) && inactArmed &&
                    (inactSamples != 8'h00) &&
                    (8'(inactCnt + 8'h01) == inactSamples);
  assign ffEvt    = sampleValid && (&ffLow);
  assign tapEvt   = sampleValid && (|tapHit) && !tapPrev;
  assign rdCause  = regRead && (regAddr == OFS_INTERRUPT_CAUSE);

  // next state of the control core
  always_comb
  begin
    next_rateReg    = rateReg;
    next_fmtReg     = fmtReg;
    next_motionStat = motionStat;
    next_linkState  = linkState;
    next_asleep     = asleep;
    next_inactCnt   = inactCnt;
    next_tapPrev    = sampleValid ? (|tapHit) : tapPrev;
    next_decimCnt   = sampleValid ? DECIM_W'(decimCnt + 1'b1) : decimCnt;
    next_dataReady  = decimEvt; // low power never gates this
    next_dataOut    = dataOut;
    if (decimEvt)
      next_dataOut = '{x: scaled[0], y: scaled[1], z: scaled[2]};
    // register writes; unused and reserved bits are dropped
    if (regWrite && regAddr == OFS_RATE_AND_POWER)
      next_rateReg = regWrData & RATE_WR_MASK;
    if (regWrite && regAddr == OFS_OUTPUT_FORMAT)
      next_fmtReg = regWrData & FORMAT_WR_MASK;
    // read clears, but an event in the same cycle still lands
    next_cause = rdCause ? 8'h00 : cause;
    next_cause[CAUSE_DRDY]  = next_cause[CAUSE_DRDY]
                              | (decimEvt && !asleep);
    next_cause[CAUSE_ACT]   = next_cause[CAUSE_ACT] | actEvt;
    next_cause[CAUSE_INACT] = next_cause[CAUSE_INACT] | inactEvt;
    next_cause[CAUSE_FFALL] = next_cause[CAUSE_FFALL] | ffEvt;
    next_cause[CAUSE_TAP]   = next_cause[CAUSE_TAP] | tapEvt;
    // consecutive quiet samples; restarts on motion or when fired
    if (sampleValid)
      next_inactCnt = (!(&inactLow) || inactEvt) ? 8'h00
                      : ((inactCnt == 8'hFF) ? inactCnt
                                             : 8'(inactCnt + 8'h01));
    // status keeps the last source axes; overwritten, never cleared
    if (actEvt)
      next_motionStat[STAT_ACT_X:STAT_ACT_Z] = {actHit[0], actHit[1],
                                                actHit[2]};
    if (tapEvt)
      next_motionStat[STAT_TAP_X:0] = {tapHit[0], tapHit[1], tapHit[2]};
    // link alternation between the two detectors
    if (!linkEnable)
      next_linkState = WATCH_INACT;
    else if (inactEvt)
      next_linkState = WATCH_ACT;
    else if (actEvt)
      next_linkState = WATCH_INACT;
    // autosleep needs link and no pending activity flag
    if (actEvt)
      next_asleep = 1'b0;
    else if (inactEvt && linkEnable && autoSleepEnable && !cause[CAUSE_ACT])
      next_asleep = 1'b1;
    else if (!linkEnable || !autoSleepEnable)
      next_asleep = 1'b0;
    // read mux, answer one cycle after the strobe
    case (regAddr)
      OFS_MOTION_TAP_STATUS:
        next_regRdData = {1'b0, motionStat[6:4], asleep,
                          motionStat[2:0]};
      OFS_RATE_AND_POWER:    next_regRdData = rateReg;
      OFS_INTERRUPT_CAUSE:   next_regRdData = cause;
      OFS_OUTPUT_FORMAT:     next_regRdData = fmtReg;
      default:               next_regRdData = 8'h00;
    endcase
    if (!regRead)
      next_regRdData = regRdData;
  end

  // state registers of the control core
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rateReg    <= RATE_RESET;
      fmtReg     <= FORMAT_RESET;
      cause      <= 8'h00;
      motionStat <= 7'h00;
      linkState  <= WATCH_INACT;
      asleep     <= 1'b0;
      inactCnt   <= 8'h00;
      decimCnt   <= '0;
      tapPrev    <= 1'b0;
      regRdData  <= 8'h00;
      dataOut    <= '0;
      dataReady  <= 1'b0;
    end
    else
    begin
      rateReg    <= next_rateReg;
      fmtReg     <= next_fmtReg;
      cause      <= next_cause;
      motionStat <= next_motionStat;
      linkState  <= next_linkState;
      asleep     <= next_asleep;
      inactCnt   <= next_inactCnt;
      decimCnt   <= next_decimCnt;
      tapPrev    <= next_tapPrev;
      regRdData  <= next_regRdData;
      dataOut    <= next_dataOut;
      dataReady  <= next_dataReady;
    end
  end

  // mode and interrupt outputs straight from control registers
  assign intOut       = |(cause & intEnable);
  assign lowPowerMode = rateReg[RATE_LOW_POWER];
  assign fastRate     = rateReg[RATE_FIELD_HI:0] >= RATE_100HZ;
  assign selfTestOn   = fmtReg[FMT_SELF_TEST];

  // every check runs on the rising clock and rests while in reset
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_shared_decim;
    dataReady |-> ($past(decimCnt & rateMask) == $past(rateMask));
  endproperty
  a_shared_decim: assert property (p_shared_decim)
    else $error("data ready off the decimation boundary");
  property p_link_arm;
    (linkEnable && linkState == WATCH_INACT && !cause[CAUSE_ACT])
      |=> !cause[CAUSE_ACT];
  endproperty
  a_link_arm: assert property (p_link_arm)
    else $error("activity fired before inactivity in link mode");
  property p_read_clear;
    (rdCause && !actEvt && !inactEvt)
      |=> !cause[CAUSE_ACT] && !cause[CAUSE_INACT];
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("cause read did not clear motion flags");
  property p_no_sleep_pending;
    $rose(asleep) |-> !$past(cause[CAUSE_ACT]);
  endproperty
  a_no_sleep_pending: assert property (p_no_sleep_pending)
    else $error("autosleep entered with activity pending");
  property p_sleep_flag;
    (regRead && regAddr == OFS_MOTION_TAP_STATUS)
      |=> regRdData[STAT_ASLEEP] == $past(asleep);
  endproperty
  a_sleep_flag: assert property (p_sleep_flag)
    else $error("status read shows wrong asleep flag");
  property p_no_drdy_asleep;
    (asleep && !cause[CAUSE_DRDY]) |=> !cause[CAUSE_DRDY];
  endproperty
  a_no_drdy_asleep: assert property (p_no_drdy_asleep)
    else $error("data ready flagged while asleep");
  property p_low_power_runs;
    (lowPowerMode && decimEvt) |=> dataReady;
  endproperty
  a_low_power_runs: assert property (p_low_power_runs)
    else $error("low power stopped data collection");
  property p_rate_100;
    (rateReg[RATE_FIELD_HI:0] == RATE_100HZ && sampleValid
      && decimCnt[4:0] == 5'h1F) |=> dataReady;
  endproperty
  a_rate_100: assert property (p_rate_100)
    else $error("code 0x0A does not decimate by 32");
  property p_full_res;
    (dataReady && $past(fmtReg[FMT_FULL_RES]))
      |-> dataOut.x == $past(filt[0]);
  endproperty
  a_full_res: assert property (p_full_res)
    else $error("full resolution output was rescaled");
  property p_self_test;
    sampleValid |-> SAMPLE_W'(stAx[2] - rawAx[2])
      == (selfTestOn ? ST_SHIFT : 13'sh0000);
  endproperty
  a_self_test: assert property (p_self_test)
    else $error("self-test shift wrong for current format bit");

endmodule : accel_motion_power_selftest_ctrl

/* src/accel_ctrl_pkg.sv */
// constants, register map and types shared by the accelerometer control logic
package accel_ctrl_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] OFS_MOTION_TAP_STATUS = 8'h2B;
  localparam logic [7:0] OFS_RATE_AND_POWER    = 8'h2C;
  localparam logic [7:0] OFS_INTERRUPT_CAUSE   = 8'h30;
  localparam logic [7:0] OFS_OUTPUT_FORMAT     = 8'h31;

  // interrupt_cause bit positions
  localparam int CAUSE_DRDY  = 7;
  localparam int CAUSE_TAP   = 6;
  localparam int CAUSE_ACT   = 4;
  localparam int CAUSE_INACT = 3;
  localparam int CAUSE_FFALL = 2;

  // motion_tap_status bit positions (x, y, z in falling order)
  localparam int STAT_ACT_X  = 6;
  localparam int STAT_ACT_Z  = 4;
  localparam int STAT_ASLEEP = 3;
  localparam int STAT_TAP_X  = 2;

  // rate_and_power fields
  localparam int RATE_LOW_POWER = 4;
  localparam int RATE_FIELD_HI  = 3;
  localparam logic [7:0] RATE_RESET    = 8'h0A;
  localparam logic [7:0] RATE_WR_MASK  = 8'h1F;
  localparam logic [3:0] RATE_100HZ    = 4'hA;

  // output_format_control fields
  localparam int FMT_SELF_TEST = 7;
  localparam int FMT_FULL_RES  = 3;
  localparam logic [7:0] FORMAT_RESET   = 8'h00;
  localparam logic [7:0] FORMAT_WR_MASK = 8'hEF;
  localparam logic [1:0] RANGE_16G      = 2'h3;

  // sample geometry and decimation counter width
  localparam int SAMPLE_W = 13;
  localparam int AXES     = 3;
  localparam int DECIM_W  = 15;
  localparam logic [DECIM_W-1:0] DECIM_FULL = 15'h7FFF;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] x;
    logic signed [SAMPLE_W-1:0] y;
    logic signed [SAMPLE_W-1:0] z;
  } axes_t;

  typedef enum logic [0:0] {
    WATCH_INACT = 1'b0,
    WATCH_ACT   = 1'b1
  } link_state_t;

endpackage : accel_ctrl_pkg

/* sim/accel_host_model.sv */
// host processor model driving the device's register port
`timescale 1ns/1ns
module accel_host_model
(
  // clock
  input  wire logic       clk,
  // register port toward the device
  output logic      [7:0] regAddr,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData
);
  // quiet port from time zero so reset never sees a stray strobe
  initial
  begin
    regAddr   = 8'h00;
    regWrite  = 1'b0;
    regRead   = 1'b0;
    regWrData = 8'h00;
  end

  // one write: address and data held across exactly one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #5;
    regAddr   = a;
    regWrData = d;
    regWrite  = 1'b1;
    @(posedge clk);
    #5;
    regWrite  = 1'b0;
    regWrData = ~d; // stale data must not look valid
  endtask : wr

  // one read: data registers at the taking edge, settled 5 ns later;
  // reading the cause register is how the host services its flags
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #5;
    regAddr = a;
    regRead = 1'b1;
    @(posedge clk);
    #5;
    regRead = 1'b0;
    d       = regRdData;
  endtask : rd
endmodule : accel_host_model

/* sim/accel_motion_power_selftest_ctrl_tb.sv */
// self-checking bench for the accelerometer control block
`timescale 1ns/1ns
module accel_motion_power_selftest_ctrl_tb;
  import accel_ctrl_pkg::*;
  localparam int ST = 128; // self-test shift handed to the design

  logic       clk, rst_n, regWrite, regRead, sampleValid, linkEnable;
  logic       autoSleepEnable, dataReady, intOut, asleep;
  logic       lowPowerMode, fastRate, selfTestOn;
  logic [7:0] regAddr, regWrData, regRdData, actThresh, inactThresh;
  logic [7:0] inactSamples, intEnable, rdv, ffThresh, tapThresh;
  axes_t      rawSample, dataOut;
  int         errTotal, comparisons, drCnt, sOff, sOn;

  accel_host_model u_host (.clk(clk), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData),
    .regRdData(regRdData));

  accel_motion_power_selftest_ctrl #(.ST_SHIFT(13'sh0080)) u_dut (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
    .sampleValid(sampleValid), .rawSample(rawSample),
    .actThresh(actThresh), .inactThresh(inactThresh),
    .inactSamples(inactSamples), .ffThresh(ffThresh), .tapThresh(tapThresh),
    .linkEnable(linkEnable), .autoSleepEnable(autoSleepEnable),
    .intEnable(intEnable), .dataOut(dataOut), .dataReady(dataReady),
    .intOut(intOut), .asleep(asleep), .lowPowerMode(lowPowerMode),
    .fastRate(fastRate), .selfTestOn(selfTestOn));

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errTotal++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      errTotal++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk1

  task automatic rdChk(input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] exp);
    u_host.rd(a, rdv);
    chk8(rdv & m, exp);
  endtask : rdChk

  // one raw sample on x, y and z at rest; dataReady is seen one cycle on
  task automatic smp(input logic signed [12:0] x);
    @(posedge clk);
    #5;
    rawSample   = '{x: x, y: 13'sh0000, z: 13'sh0000};
    sampleValid = 1'b1;
    @(posedge clk);
    #5;
    sampleValid = 1'b0;
    rawSample   = ~rawSample; // idle pattern, never a plausible sample
    if (dataReady === 1'b1)
      drCnt++;
  endtask : smp

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // watchdog at 40000 cycles; the tests need well under 4000
  initial
  begin
    #2000000;
    errTotal++;
    conclude();
  end

  initial
  begin
    {rst_n, sampleValid, linkEnable, autoSleepEnable} = 4'h0;
    rawSample = '0;
    {actThresh, inactThresh, inactSamples, intEnable} = 32'h0804_0010;
    {ffThresh, tapThresh} = 16'h00FF;
    errTotal = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    #5 rst_n = 1'b1;
    // reset values and refused places
    chk1(fastRate, 1'b1);
    rdChk(OFS_RATE_AND_POWER, 8'hFF, 8'h0A);
    rdChk(OFS_OUTPUT_FORMAT, 8'hFF, 8'h00);
    rdChk(8'h55, 8'hFF, 8'h00);
    $display("test reset done");
    // every rate code, then reserved bits
    for (int c = 0; c < 16; c++)
    begin
      u_host.wr(OFS_RATE_AND_POWER, 8'(c));
      chk1(fastRate, c >= 10);
    end
    u_host.wr(OFS_RATE_AND_POWER, 8'hE5);
    rdChk(OFS_RATE_AND_POWER, 8'hFF, 8'h05);
    $display("test rate done");
    // one shared stream decimated: full rate, half rate, low power
    u_host.wr(OFS_RATE_AND_POWER, 8'h0F);
    drCnt = 0;
    repeat (8) smp(13'sh0000);
    chk8(8'(drCnt), 8'h08);
    u_host.wr(OFS_RATE_AND_POWER, 8'h0E);
    drCnt = 0;
    repeat (8) smp(13'sh0000);
    chk8(8'(drCnt), 8'h04);
    // reset code 0x0A keeps one output in every 32 samples
    u_host.wr(OFS_RATE_AND_POWER, 8'h0A);
    drCnt = 0;
    repeat (32) smp(13'sh0000);
    chk8(8'(drCnt), 8'h01);
    // low power keeps collecting; rate code 0x0F with the low-power bit set
    u_host.wr(OFS_RATE_AND_POWER, 8'h1F);
    chk1(lowPowerMode, 1'b1);
    drCnt = 0;
    repeat (8) smp(13'sh0000);
    chk8(8'(drCnt), 8'h08);
    $display("test decimation done");
    // a spike fires activity though the filtered output stays below it
    u_host.rd(OFS_INTERRUPT_CAUSE, rdv);
    smp(13'sh00C8);
    chk8(dataOut.x[7:0], 8'h00);
    chk1(intOut, 1'b1);
    rdChk(OFS_INTERRUPT_CAUSE, 8'hFF, 8'h90);
    chk1(intOut, 1'b0);
    rdChk(OFS_INTERRUPT_CAUSE, 8'hFF, 8'h00);
    rdChk(OFS_MOTION_TAP_STATUS, 8'hF8, 8'h40);
    $display("test activity done");
    // link and autosleep
    {linkEnable, autoSleepEnable, inactSamples} = 10'h302;
    smp(13'sh00C8);
    chk8(dataOut.x[7:0], 8'h64);
    rdChk(OFS_INTERRUPT_CAUSE, 8'h18, 8'h00);
    repeat (2) smp(13'sh0000);
    chk1(asleep, 1'b1);
    rdChk(OFS_MOTION_TAP_STATUS, 8'h08, 8'h08);
    rdChk(OFS_INTERRUPT_CAUSE, 8'h18, 8'h08);
    drCnt = 0;
    smp(13'sh0000);
    chk8(8'(drCnt), 8'h01);
    rdChk(OFS_INTERRUPT_CAUSE, 8'hFF, 8'h00);
    smp(13'sh00C8);
    chk1(asleep, 1'b0);
    repeat (2) smp(13'sh0000);
    chk1(asleep, 1'b0);
    rdChk(OFS_INTERRUPT_CAUSE, 8'h18, 8'h18);
    {linkEnable, autoSleepEnable, inactSamples} = 10'h000;
    $display("test link done");
    // self-test: full resolution 16 g, settle, equal sets off and on
    u_host.wr(OFS_OUTPUT_FORMAT, 8'hFB);
    chk1(selfTestOn, 1'b1);
    rdChk(OFS_OUTPUT_FORMAT, 8'hFF, 8'hEB);
    u_host.wr(OFS_OUTPUT_FORMAT, 8'h0B);
    chk1(selfTestOn, 1'b0);
    u_host.wr(OFS_RATE_AND_POWER, 8'h0F);
    {sOff, sOn} = 64'h0;
    repeat (12) smp(13'sh0000);
    repeat (4)
    begin
      smp(13'sh0000);
      sOff += int'(dataOut.x);
    end
    u_host.wr(OFS_OUTPUT_FORMAT, 8'h8B);
    repeat (4) smp(13'sh0000);
    repeat (4)
    begin
      smp(13'sh0000);
      sOn += int'(dataOut.x);
    end
    sOn -= sOff; // on minus off is the self-test change
    chk1(sOn >= 4 * (ST - 8) && sOn <= 4 * ST, 1'b1);
    u_host.wr(OFS_OUTPUT_FORMAT, 8'h0B);
    chk1(selfTestOn, 1'b0);
    $display("test self-test done");
    // tap and free-fall also judge the raw samples
    {ffThresh, tapThresh} = 16'h020A;
    u_host.rd(OFS_INTERRUPT_CAUSE, rdv);
    smp(13'sh00C8);
    smp(13'sh0000);
    rdChk(OFS_INTERRUPT_CAUSE, 8'h44, 8'h44);
    rdChk(OFS_MOTION_TAP_STATUS, 8'h07, 8'h04);
    $display("test tap done");
    conclude();
  end
endmodule : accel_motion_power_selftest_ctrl_tb
